/* File: serial_adc_readout_port.sv */
module serial_adc_readout_port
#(
  parameter int WIDTH = readout_pkg::FIFO_WIDTH,
  parameter int DEPTH = readout_pkg::FIFO_DEPTH
) (
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire readout_pkg::link_in_t link_in,
  output readout_pkg::link_out_t link_out,
  input wire logic sample_valid,
  output logic sample_ready,
  input wire logic [WIDTH-1:0] sample_data,
  output logic tracking,
  output logic busy,
  output logic frame_done,
  output logic quiet_violation
);
  import readout_pkg::*;

  logic [1:0] sel_sync_q;
  logic [1:0] sclk_sync_q;
  logic sel_n_q;
  logic sclk_q;
  logic sclk_rise;
  logic sclk_fall;
  logic sel_fall;
  logic sel_rise;
  frame_state_t state_q;
  logic [4:0] rise_cnt_q;
  logic [4:0] fall_cnt_q;
  logic [FRAME_BITS-1:0] shift_q;
  logic data_q;
  logic oe_n_q;
  logic tracking_q;
  logic busy_q;
  logic done_q;
  logic qv_q;
  logic [3:0] quiet_q;
  logic fifo_valid;
  logic fifo_pop;
  logic [WIDTH-1:0] fifo_data;

  // Link pins are asynchronous to ref_clk; sync first, detect edges after
  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      sel_sync_q <= 2'h3;
      sclk_sync_q <= 2'h3;
      sel_n_q <= 1'b1;
      sclk_q <= 1'b1;
    end
    else
    begin
      sel_sync_q <= {sel_sync_q[0], link_in.sel_n};
      sclk_sync_q <= {sclk_sync_q[0], link_in.sclk};
      sel_n_q <= sel_sync_q[1];
      sclk_q <= sclk_sync_q[1];
    end
  end

  assign sclk_rise = sclk_sync_q[1] && !sclk_q;
  assign sclk_fall = !sclk_sync_q[1] && sclk_q;
  assign sel_fall = !sel_sync_q[1] && sel_n_q;
  assign sel_rise = sel_sync_q[1] && !sel_n_q;
  // A result is taken only at frame start, the sample instant
  assign fifo_pop = sel_fall && fifo_valid;

  sample_fifo #(
    .WIDTH(WIDTH),
    .DEPTH(DEPTH)
  ) u_fifo (
    .ref_clk(ref_clk),
    .arst_n(arst_n),
    .in_valid(sample_valid),
    .in_ready(sample_ready),
    .in_data(sample_data),
    .out_valid(fifo_valid),
    .out_ready(fifo_pop),
    .out_data(fifo_data)
  );

  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      state_q <= ST_IDLE;
    end
    else if (sel_rise)
    begin
      state_q <= ST_IDLE;
    end
    else
    begin
      unique case (state_q)
        ST_IDLE:
        begin
          if (sel_fall)
          begin
            state_q <= ST_FRAME;
          end
        end
        ST_FRAME:
        begin
          if (sclk_fall && fall_cnt_q == 5'(FRAME_BITS - 1))
          begin
            state_q <= ST_DONE;
          end
        end
        ST_DONE:
        begin
          state_q <= ST_DONE;
        end
      endcase
    end
  end

  // Conversion progress counts host clock edges only
  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      rise_cnt_q <= BIT_CNT_RESET;
      fall_cnt_q <= BIT_CNT_RESET;
    end
    else if (sel_fall)
    begin
      rise_cnt_q <= BIT_CNT_RESET;
      fall_cnt_q <= BIT_CNT_RESET;
    end
    else if (state_q == ST_FRAME)
    begin
      if (sclk_rise && rise_cnt_q != 5'(FRAME_BITS))
      begin
        rise_cnt_q <= rise_cnt_q + 5'h01;
      end
      if (sclk_fall && fall_cnt_q != 5'(FRAME_BITS))
      begin
        fall_cnt_q <= fall_cnt_q + 5'h01;
      end
    end
  end

  // Empty FIFO converts as zero; code is plain unsigned binary
  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      shift_q <= '0;
    end
    else if (sel_fall)
    begin
      shift_q <= {LEAD_ZEROS'(0), fifo_valid ? fifo_data[RESULT_BITS-1:0] : RESULT_RESET};
    end
    else if (state_q == ST_FRAME && sclk_fall)
    begin
      shift_q <= {shift_q[FRAME_BITS-2:0], 1'b0};
    end
  end

  // Output driven from select fall; first zero appears then, rest on falls
  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      data_q <= 1'b0;
      oe_n_q <= 1'b1;
    end
    else if (sel_fall)
    begin
      data_q <= 1'b0;
      oe_n_q <= 1'b0;
    end
    else if (sel_rise)
    begin
      oe_n_q <= 1'b1;
      data_q <= 1'b0;
    end
    else if (state_q == ST_FRAME && sclk_fall)
    begin
      data_q <= shift_q[FRAME_BITS-2];
      if (fall_cnt_q == 5'(FRAME_BITS - 1))
      begin
        oe_n_q <= 1'b1;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      tracking_q <= 1'b1;
      busy_q <= 1'b0;
      done_q <= 1'b0;
    end
    else
    begin
      done_q <= state_q == ST_FRAME && sclk_fall && fall_cnt_q == 5'(FRAME_BITS - 1);
      if (sel_fall)
      begin
        tracking_q <= 1'b0;
        busy_q <= 1'b1;
      end
      else if (state_q == ST_FRAME && sclk_rise && rise_cnt_q == 5'(TRACK_EDGE - 1))
      begin
        tracking_q <= 1'b1;
        busy_q <= 1'b0;
      end
      else if (sel_rise)
      begin
        tracking_q <= 1'b1;
        busy_q <= 1'b0;
      end
    end
  end

  // Select high time in cycles; the cycle that sees the rise counts as one
  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      quiet_q <= 4'(QUIET_CYCLES);
      qv_q <= 1'b0;
    end
    else if (sel_rise)
    begin
      quiet_q <= 4'h1;
    end
    else if (sel_fall)
    begin
      qv_q <= quiet_q < 4'(QUIET_CYCLES);
    end
    else if (sel_n_q && quiet_q < 4'(QUIET_CYCLES))
    begin
      quiet_q <= quiet_q + 4'h1;
    end
  end

  assign link_out = '{data: data_q, data_oe_n: oe_n_q};
  assign tracking = tracking_q;
  assign busy = busy_q;
  assign frame_done = done_q;
  assign quiet_violation = qv_q;

  sequence s_start;
    sel_fall;
  endsequence
  property p_oe_on_start;
    @(posedge ref_clk) disable iff (!arst_n)
    s_start |=> !link_out.data_oe_n && !link_out.data && !tracking;
  endproperty
  a_oe_on_start: assert property (p_oe_on_start) else $error("start did not enable output");
  property p_shift_on_fall;
    @(posedge ref_clk) disable iff (!arst_n)
    (state_q == ST_FRAME && sclk_fall && !sel_rise) |=> link_out.data == $past(shift_q[14]);
  endproperty
  a_shift_on_fall: assert property (p_shift_on_fall) else $error("bit not advanced on fall");
  property p_lead_zero;
    @(posedge ref_clk) disable iff (!arst_n)
    (state_q == ST_FRAME && sclk_fall && fall_cnt_q < 5'h3) |=> !link_out.data;
  endproperty
  a_lead_zero: assert property (p_lead_zero) else $error("leading bit not zero");
  property p_track13;
    @(posedge ref_clk) disable iff (!arst_n)
    (state_q == ST_FRAME && sclk_rise && rise_cnt_q == 5'hC && !sel_rise) |=> tracking;
  endproperty
  a_track13: assert property (p_track13) else $error("no tracking on 13th rise");
  property p_hold_early;
    @(posedge ref_clk) disable iff (!arst_n)
    (busy && rise_cnt_q < 5'hC && !sclk_rise && !sel_rise && !sel_fall) |=> !tracking;
  endproperty
  a_hold_early: assert property (p_hold_early) else $error("tracking too early");
  property p_no_progress;
    @(posedge ref_clk) disable iff (!arst_n)
    (!sclk_rise && !sel_fall) |=> $stable(rise_cnt_q);
  endproperty
  a_no_progress: assert property (p_no_progress) else $error("progress without clock");
  property p_msb_load;
    @(posedge ref_clk) disable iff (!arst_n)
    (sel_fall && fifo_valid) |=> shift_q == {4'h0, $past(fifo_data)};
  endproperty
  a_msb_load: assert property (p_msb_load) else $error("frame word mis-loaded");
  property p_release;
    @(posedge ref_clk) disable iff (!arst_n)
    sel_rise |=> link_out.data_oe_n ##1 link_out.data_oe_n;
  endproperty
  a_release: assert property (p_release) else $error("output not released");
endmodule

/* File: readout_pkg.sv */
package readout_pkg;
  localparam int RESULT_BITS = 12;
  localparam int LEAD_ZEROS = 4;
  localparam int FRAME_BITS = 16;
  localparam int TRACK_EDGE = 13;
  localparam int FIFO_WIDTH = 12;
  localparam int FIFO_DEPTH = 16;
  localparam int CLK_PERIOD_NS = 40;
  localparam int QUIET_NS = 100;
  localparam int QUIET_CYCLES = (QUIET_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [4:0] BIT_CNT_RESET = 5'h00;
  localparam logic [11:0] RESULT_RESET = 12'h000;

  typedef struct packed {
    logic sel_n;
    logic sclk;
  } link_in_t;

  typedef struct packed {
    logic data;
    logic data_oe_n;
  } link_out_t;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_FRAME,
    ST_DONE
  } frame_state_t;
endpackage

/* File: sample_fifo.sv */
module sample_fifo #(
  parameter int WIDTH = 12,
  parameter int DEPTH = 16
) (
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0] wr_q;
  logic [AW-1:0] rd_q;
  logic [AW:0] cnt_q;
  logic push;
  logic pop;
  logic room_q;
  logic [AW:0] cnt_d;

  // Ready is registered so that the block's ready output comes from a flop
  assign in_ready = room_q;
  assign cnt_d = cnt_q + (AW+1)'(push) - (AW+1)'(pop);
  assign out_valid = (cnt_q != '0);
  assign out_data = mem_q[rd_q];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always_ff @(posedge ref_clk)
  begin
    if (push)
    begin
      mem_q[wr_q] <= in_data;
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
      room_q <= 1'b1;
    end
    else
    begin
      if (push)
      begin
        wr_q <= (wr_q == AW'(DEPTH - 1)) ? '0 : wr_q + 1'b1;
      end
      if (pop)
      begin
        rd_q <= (rd_q == AW'(DEPTH - 1)) ? '0 : rd_q + 1'b1;
      end
      cnt_q <= cnt_d;
      room_q <= cnt_d != (AW+1)'(DEPTH);
    end
  end
endmodule

/* File: host_model.sv */
module host_model (
  input wire logic ref_clk,
  output readout_pkg::link_in_t link_in,
  input wire readout_pkg::link_out_t link_out,
  input wire logic tracking,
  input wire logic busy
);
  timeunit 1ns;
  timeprecision 1ps;
  import readout_pkg::*;
  logic [15:0] word;
  logic [16:0] oe;
  logic trk12, bsy12, trk13, bsy13;
  logic pin_level;

  // A released line is pulled up on the host's side
  assign pin_level = link_out.data_oe_n ? 1'b1 : link_out.data;

  // Clock idles high and stands still between frames
  initial link_in = '{sel_n: 1'b1, sclk: 1'b1};

  // Pins move on the falling ref_clk edge. The select fall launches the first
  // bit, taken before the first serial fall; every later bit is taken at the
  // serial rise after the fall that launched it, which leaves half a serial
  // period for the device's synchroniser delay
  task automatic frame(input int quiet, input int stall);
    repeat (quiet) @(negedge ref_clk);
    link_in.sel_n = 1'b0;
    repeat (8) @(negedge ref_clk);
    word[FRAME_BITS-1] = pin_level;
    for (int n = 1; n <= FRAME_BITS; n++)
    begin
      oe[n-1] = link_out.data_oe_n;
      link_in.sclk = 1'b0;
      repeat (2) @(negedge ref_clk);
      if (n == TRACK_EDGE)
      begin
        trk12 = tracking;
        bsy12 = busy;
      end
      if (n == TRACK_EDGE + 1)
      begin
        trk13 = tracking;
        bsy13 = busy;
      end
      repeat (2) @(negedge ref_clk);
      link_in.sclk = 1'b1;
      if (n < FRAME_BITS)
      begin
        word[FRAME_BITS-1-n] = pin_level;
      end
      // A long high phase shows that only the serial clock paces the work
      repeat ((n == 5) ? stall + 4 : 4) @(negedge ref_clk);
    end
    oe[16] = link_out.data_oe_n;
    link_in.sel_n = 1'b1;
  endtask
endmodule

/* File: serial_adc_readout_port_bench.sv */
module serial_adc_readout_port_bench;
  timeunit 1ns;
  timeprecision 1ps;
  import readout_pkg::*;
  logic ref_clk = 1'b0;
  logic arst_n = 1'b0;
  link_in_t link_in;
  link_out_t link_out;
  logic sample_valid = 1'b0;
  logic sample_ready, tracking, busy, frame_done, quiet_violation;
  logic [11:0] sample_data = 12'h000;
  logic [31:0] rnd = 32'h3F92;
  logic [11:0] exp_q[$];
  int error_cnt = 0;
  int tests_run = 0;
  int done_cnt = 0;

  initial forever #20 ref_clk = ~ref_clk;
  // Sampled away from the edge that launches the pulse
  always @(negedge ref_clk) if (frame_done === 1'b1) done_cnt++;

  serial_adc_readout_port i_dut (.ref_clk(ref_clk), .arst_n(arst_n), .link_in(link_in),
    .link_out(link_out), .sample_valid(sample_valid), .sample_ready(sample_ready),
    .sample_data(sample_data), .tracking(tracking), .busy(busy), .frame_done(frame_done),
    .quiet_violation(quiet_violation));
  host_model i_host (.ref_clk(ref_clk), .link_in(link_in), .link_out(link_out),
    .tracking(tracking), .busy(busy));

  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {1'b0, x[31:1]} ^ (x[0] ? 32'h80200003 : 32'h0);
  endfunction

  function automatic logic [15:0] frame_word(input logic [11:0] v);
    return {{LEAD_ZEROS{1'b0}}, v};
  endfunction

  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
    tests_run++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic conclude();
    $display("checks %0d mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // A push into a full buffer must be refused and leave the queue untouched
  task automatic push(input logic [11:0] v, input logic room);
    @(negedge ref_clk);
    check("sample_ready", 16'(room), 16'(sample_ready));
    sample_valid = 1'b1;
    sample_data = v;
    @(negedge ref_clk);
    sample_valid = 1'b0;
    if (room)
      exp_q.push_back(v);
  endtask

  initial
  begin
    logic [11:0] v;
    logic [15:0] e;
    repeat (10) @(posedge ref_clk);
    @(negedge ref_clk);
    arst_n = 1'b1;
    repeat (4) @(negedge ref_clk);
    for (int i = 0; i <= FIFO_DEPTH; i++)
    begin
      rnd = lfsr(rnd);
      v = (i == 0) ? 12'h000 : (i == 1) ? 12'hFFF : rnd[11:0];
      push(v, i < FIFO_DEPTH);
    end
    $display("buffer fill test done");
    // The last frame finds the buffer empty and must carry a zero result
    for (int i = 0; i <= FIFO_DEPTH; i++)
    begin
      e = frame_word((exp_q.size() > 0) ? exp_q.pop_front() : 12'h000);
      i_host.frame((i == 4) ? 2 : 3, (i == 2) ? 40 : 0);
      check("result word", e, i_host.word);
      check("driving in frame", 16'h0, i_host.oe[15:0]);
      check("released after", 16'h1, 16'(i_host.oe[16]));
      check("tracking after 12 rises", 16'h0, 16'(i_host.trk12));
      check("busy after 12 rises", 16'h1, 16'(i_host.bsy12));
      check("tracking after 13 rises", 16'h1, 16'(i_host.trk13));
      check("busy after 13 rises", 16'h0, 16'(i_host.bsy13));
      check("quiet flag", 16'(i == 4), 16'(quiet_violation));
      check("frame done count", 16'(i + 1), 16'(done_cnt));
      $display("frame test %0d done", i);
    end
    conclude();
  end

  initial
  begin
    #500us;
    error_cnt++;
    conclude();
  end
endmodule
